// ===== design/chan_digital_post_process.sv
// Digital high-pass filter and lane test patterns for channels 13 to 16,
// gain and offset for channel 16 only, with an APB register slave.
// Assumes samples arrive on pclk from on-chip logic, so no synchroniser.
//
// Local design decision: register access over APB.

`timescale 1ns/10ps
`default_nettype none

module chan_digital_post_process (
    // Clock and reset.
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Sample stream in.
    input  wire logic                 sample_valid,
    input  wire logic [13:0]          sample_ch13,
    input  wire logic [13:0]          sample_ch14,
    input  wire logic [13:0]          sample_ch15,
    input  wire logic [13:0]          sample_ch16,
    // Serial lane words out.
    output logic      [13:0]          lane13_data,
    output logic      [13:0]          lane14_data,
    output logic      [13:0]          lane15_data,
    output logic      [13:0]          lane16_data,
    output logic                      lane_valid
);

    // ==========================================================
    // State
    // ==========================================================
    // Configuration, bus answer, filter history and lane words in one register.
    typedef struct packed {
        logic [15:0]       global_ctrl;
        logic [15:0]       pat_mode;
        logic [15:0]       gain_offset;
        logic [15:0]       offset_copy;
        logic [15:0]       lane_hpf;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic [3:0][13:0]  x_prev;
        logic [3:0][31:0]  y_prev;
        logic [3:0][13:0]  hp;
        logic              hp_vld;
        logic [3:0][14:0]  prbs;
        logic [13:0]       ramp;
        logic              toggle;
        logic [3:0][13:0]  lane;
        logic              lane_vld;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // ==========================================================
    // Helpers
    // ==========================================================

    // Clamps a wide signed value to the sample range.
    // Without it a large gain or offset would wrap the sign.
    function automatic logic [13:0] sat_word(input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = 32'sh0000_1FFF;
        lo = -32'sh0000_2000;
        if (v > hi) begin
            return 14'h1FFF;
        end else if (v < lo) begin
            return 14'h2000;
        end else begin
            return v[13:0];
        end
    endfunction : sat_word

    // Merges the low two byte lanes of a write into a 16-bit register.
    // Strobes 2 and 3 are ignored; no strobe changes nothing.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge

    // Chooses the word for a lane from its pattern code.
    // Unused codes fall back to the live sample.
    function automatic logic [13:0] pick(input logic [2:0]  code,
                                         input logic [13:0] normal,
                                         input logic [13:0] ramp,
                                         input logic        tog);
        case (code)
            chan_pp_pkg::PAT_ZEROS:  return 14'h0000;
            chan_pp_pkg::PAT_ONES:   return 14'h3FFF;
            chan_pp_pkg::PAT_TOGGLE: begin
                return tog ? chan_pp_pkg::TOGGLE_B : chan_pp_pkg::TOGGLE_A;
            end
            chan_pp_pkg::PAT_RAMP:   return ramp;
            default:                 return normal;
        endcase
    endfunction : pick

    // ==========================================================
    // Next-state logic
    // ==========================================================

    // Bus decode, filter, gain, offset and lane selection.
    // Every field holds its value unless a branch below changes it.
    always_comb begin
        logic [9:0]          idx;
        logic                hit;
        logic [31:0]         rd;
        logic                done;
        logic [3:0][13:0]    x_in;
        logic [3:0]          k;
        logic [5:0]          k2;
        logic [5:0]          k3;
        logic [5:0]          k4;
        logic signed [31:0]  s;
        logic signed [31:0]  y;
        logic signed [31:0]  prod;
        logic signed [31:0]  g16;
        logic                sel;
        logic [13:0]         w13;
        logic [13:0]         w14;
        idx  = paddr[11:2];
        hit  = 1'b0;
        rd   = 32'h0000_0000;
        done = 1'b0;
        x_in = {sample_ch16, sample_ch15, sample_ch14, sample_ch13};
        k    = st_ff.lane_hpf[chan_pp_pkg::HPF_K_MSB:chan_pp_pkg::HPF_K_LSB];
        k2   = {1'b0, k, 1'b0};
        k3   = k2 + {2'b00, k};
        k4   = {k, 2'b00};
        s    = 32'sh0;
        y    = 32'sh0;
        prod = 32'sh0;
        g16  = 32'sh0;
        sel  = st_ff.pat_mode[chan_pp_pkg::LANE_SEL_BIT];
        w13  = 14'h0000;
        w14  = 14'h0000;
        nxt_st = st_ff;

        // Register read mux; reserved bits read back as written.
        // A bad index answers with an error and no data.
        case (idx)
            chan_pp_pkg::IDX_GLOBAL_CTRL: begin
                hit = 1'b1;
                rd  = {16'h0000, st_ff.global_ctrl};
            end
            chan_pp_pkg::IDX_PAT_MODE: begin
                hit = 1'b1;
                rd  = {16'h0000, st_ff.pat_mode};
            end
            chan_pp_pkg::IDX_GAIN_OFFSET: begin
                hit = 1'b1;
                rd  = {16'h0000, st_ff.gain_offset};
            end
            chan_pp_pkg::IDX_OFFSET_COPY: begin
                hit = 1'b1;
                rd  = {16'h0000, st_ff.offset_copy};
            end
            chan_pp_pkg::IDX_LANE_HPF: begin
                hit = 1'b1;
                rd  = {16'h0000, st_ff.lane_hpf};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end

        // One wait state: answer on the second access cycle.
        // It gives the read mux a full cycle before prdata shows.
        done = psel & penable & st_ff.pready;
        nxt_st.pready = psel & penable & ~st_ff.pready;
        if (psel & penable & ~st_ff.pready) begin
            nxt_st.pslverr = ~hit;
            nxt_st.prdata  = (hit & ~pwrite) ? rd : 32'h0000_0000;
        end else begin
            nxt_st.pslverr = 1'b0;
        end

        // Writes land only at the completing edge of the transfer.
        // An error answer blocks the write.
        if (done & pwrite & ~st_ff.pslverr) begin
            case (idx)
                chan_pp_pkg::IDX_GLOBAL_CTRL: begin
                    nxt_st.global_ctrl = merge(st_ff.global_ctrl, pwdata, pstrb);
                end
                chan_pp_pkg::IDX_PAT_MODE: begin
                    nxt_st.pat_mode = merge(st_ff.pat_mode, pwdata, pstrb);
                end
                chan_pp_pkg::IDX_GAIN_OFFSET: begin
                    nxt_st.gain_offset = merge(st_ff.gain_offset, pwdata, pstrb);
                end
                chan_pp_pkg::IDX_OFFSET_COPY: begin
                    nxt_st.offset_copy = merge(st_ff.offset_copy, pwdata, pstrb);
                end
                chan_pp_pkg::IDX_LANE_HPF: begin
                    nxt_st.lane_hpf = merge(st_ff.lane_hpf, pwdata, pstrb);
                end
                default: begin
                    nxt_st.lane_hpf = st_ff.lane_hpf;
                end
            endcase
        end

        // High-pass stage; the series s - s/2^k + s/2^2k - s/2^3k + s/2^4k
        // approximates s * 2^k / (2^k + 1) with error below 2^-5k.
        // Eight fraction bits in the history keep small steps.
        nxt_st.hp_vld = sample_valid;
        if (sample_valid) begin
            for (int i = 0; i < 4; i++) begin
                s = ($signed({{18{x_in[i][13]}}, x_in[i]}) <<< chan_pp_pkg::HPF_FRAC)
                  - ($signed({{18{st_ff.x_prev[i][13]}}, st_ff.x_prev[i]})
                     <<< chan_pp_pkg::HPF_FRAC)
                  + $signed(st_ff.y_prev[i]);
                // The fifth term keeps truncation within one output step.
                y = s - (s >>> k) + (s >>> k2) - (s >>> k3)
                  + (s >>> k4);
                nxt_st.x_prev[i] = x_in[i];
                if (st_ff.lane_hpf[chan_pp_pkg::HPF_ON_BIT]) begin
                    nxt_st.y_prev[i] = y;
                    nxt_st.hp[i]     = sat_word(y >>> chan_pp_pkg::HPF_FRAC);
                end else begin
                    // Bypass; history restarts cleanly when re-enabled.
                    // The input is still recorded for a true first step.
                    nxt_st.y_prev[i] = 32'h0000_0000;
                    nxt_st.hp[i]     = x_in[i];
                end
            end
        end

        // Channel 16 gain then offset.
        // They act on the filtered word, one cycle behind the filter.
        // The product shift rounds toward minus infinity.
        g16 = $signed({{18{st_ff.hp[3][13]}}, st_ff.hp[3]});
        if (st_ff.global_ctrl[chan_pp_pkg::GAIN_APPLY_BIT]) begin
            prod = g16 * $signed({16'h0000, chan_pp_pkg::GAIN_TABLE[
                st_ff.gain_offset[chan_pp_pkg::GAIN_MSB:chan_pp_pkg::GAIN_LSB]]});
            g16  = prod >>> chan_pp_pkg::GAIN_FRAC;
        end
        if (st_ff.global_ctrl[chan_pp_pkg::OFFSET_APPLY_BIT]) begin
            g16 = g16 + $signed({{22{st_ff.gain_offset[chan_pp_pkg::OFFSET_MSB]}},
                st_ff.gain_offset[chan_pp_pkg::OFFSET_MSB:chan_pp_pkg::OFFSET_LSB]});
        end

        // Lane selection; PRBS outranks the pattern code.
        // Lanes 15 and 16 have no pattern code; only PRBS overrides them.
        // All generators share a seed, so enabled lanes match.
        w13 = pick(st_ff.pat_mode[0] ? chan_pp_pkg::PAT_NORMAL :
                   st_ff.lane_hpf[chan_pp_pkg::PAT13_MSB:chan_pp_pkg::PAT13_LSB],
                   st_ff.hp[0], st_ff.ramp, st_ff.toggle);
        w14 = pick(st_ff.lane_hpf[chan_pp_pkg::PAT14_MSB:chan_pp_pkg::PAT14_LSB],
                   st_ff.hp[1], st_ff.ramp, st_ff.toggle);
        nxt_st.lane_vld = st_ff.hp_vld;
        if (st_ff.hp_vld) begin
            nxt_st.lane[0] = sel ? w13 : st_ff.hp[0];
            nxt_st.lane[1] = sel ? w14 : st_ff.hp[1];
            nxt_st.lane[2] = st_ff.hp[2];
            nxt_st.lane[3] = sat_word(g16);
            for (int i = 0; i < 4; i++) begin
                if (sel & st_ff.lane_hpf[chan_pp_pkg::PRBS13_BIT - i]) begin
                    nxt_st.lane[i] = st_ff.prbs[i][13:0];
                end
                nxt_st.prbs[i] = {st_ff.prbs[i][13:0],
                                  st_ff.prbs[i][14] ^ st_ff.prbs[i][13]};
            end
            // Ramp and toggle advance with every sample, shown or not.
            nxt_st.ramp   = st_ff.ramp + 14'h0001;
            nxt_st.toggle = ~st_ff.toggle;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================

    // All configuration clears to zero so every feature starts off.
    // PRBS generators are seeded nonzero; all-zero would never leave. Ramp and toggle clear to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff             <= '0;
            st_ff.global_ctrl <= chan_pp_pkg::REG_RESET;
            st_ff.pat_mode    <= chan_pp_pkg::REG_RESET;
            st_ff.gain_offset <= chan_pp_pkg::REG_RESET;
            st_ff.offset_copy <= chan_pp_pkg::REG_RESET;
            st_ff.lane_hpf    <= chan_pp_pkg::REG_RESET;
            st_ff.prbs        <= {4{chan_pp_pkg::PRBS_SEED}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Every output is a field of the state register.
    // Nothing here is combinational; pins change only on pclk.
    assign prdata      = st_ff.prdata;
    assign pready      = st_ff.pready;
    assign pslverr     = st_ff.pslverr;
    assign lane13_data = st_ff.lane[0];
    assign lane14_data = st_ff.lane[1];
    assign lane15_data = st_ff.lane[2];
    assign lane16_data = st_ff.lane[3];
    assign lane_valid  = st_ff.lane_vld;

endmodule : chan_digital_post_process

`default_nettype wire

// ===== inc/chan_pp_pkg.sv
// Constants for the channel 13..16 digital post-processing block.
// Assumes a single 100 MHz clock shared by the APB bus and the sample stream.

package chan_pp_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int SAMPLE_W  = 14;
    localparam int ADDR_W    = 12;
    localparam int REG_W     = 16;
    localparam int ACC_W     = 32;
    localparam int HPF_FRAC  = 8;
    localparam int GAIN_FRAC = 12;
    localparam int PRBS_W    = 15;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [9:0] IDX_GLOBAL_CTRL = 10'h003;
    localparam logic [9:0] IDX_PAT_MODE    = 10'h004;
    localparam logic [9:0] IDX_GAIN_OFFSET = 10'h037;
    localparam logic [9:0] IDX_OFFSET_COPY = 10'h038;
    localparam logic [9:0] IDX_LANE_HPF    = 10'h039;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int GAIN_APPLY_BIT   = 12;
    localparam int OFFSET_APPLY_BIT = 8;
    localparam int LANE_SEL_BIT     = 8;
    localparam int GAIN_MSB         = 15;
    localparam int GAIN_LSB         = 11;
    localparam int OFFSET_MSB       = 9;
    localparam int OFFSET_LSB       = 0;
    localparam int PRBS13_BIT       = 15;
    localparam int PAT13_MSB        = 11;
    localparam int PAT13_LSB        = 9;
    localparam int PAT14_MSB        = 8;
    localparam int PAT14_LSB        = 6;
    localparam int HPF_K_MSB        = 4;
    localparam int HPF_K_LSB        = 1;
    localparam int HPF_ON_BIT       = 0;

    // ==========================================================
    // Test pattern codes and generator seeds
    // ==========================================================
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS  = 3'h1;
    localparam logic [2:0] PAT_ONES   = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [2:0] PAT_RAMP   = 3'h4;
    localparam logic [13:0] TOGGLE_A  = 14'h2AAA;
    localparam logic [13:0] TOGGLE_B  = 14'h1555;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;

    // Gain factors for N x 0.2 dB, unsigned with GAIN_FRAC fraction bits.
    localparam logic [31:0][15:0] GAIN_TABLE = {
        16'h20AB, 16'h1FED, 16'h1F33, 16'h1E7D, 16'h1DCB, 16'h1D1D, 16'h1C74, 16'h1BCE,
        16'h1B2C, 16'h1A8E, 16'h19F3, 16'h195C, 16'h18C8, 16'h1837, 16'h17AA, 16'h1720,
        16'h169A, 16'h1616, 16'h1595, 16'h1517, 16'h149D, 16'h1425, 16'h13AF, 16'h133C,
        16'h12CC, 16'h125E, 16'h11F4, 16'h118B, 16'h1125, 16'h10C1, 16'h105F, 16'h1000
    };

endpackage : chan_pp_pkg

// ===== bench/chan_pp_props.sv
// Checker for the channel 13..16 post-processing block.
// Sees only the top module's ports; it is bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none

module chan_pp_props (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB signals.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sample stream.
    input wire logic        sample_valid,
    input wire logic        lane_valid,
    input wire logic [13:0] lane16_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ====================
    // Bus answer timing
    // ====================
    // An access cycle still waiting, and the cycle that completes it.
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence access_done;
        psel && penable && pready;
    endsequence

    ready_after_wait_a: assert property (access_wait |=> access_done)
        else $error("pready missing one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && $past(penable))
        else $error("pready without a pending access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    misalign_err_a: assert property (access_wait and paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    upper_zero_a: assert property (access_done and !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    // ====================
    // Sample stream timing
    // ====================
    lane_latency_a: assert property (sample_valid |-> ##2 lane_valid)
        else $error("lane word not two cycles after sample");
    lane_cause_a: assert property (lane_valid |-> $past(sample_valid, 2))
        else $error("lane word without a sample");
    lane_hold_a: assert property (!lane_valid |-> $stable(lane16_data))
        else $error("lane data changed between words");
endmodule : chan_pp_props

bind chan_digital_post_process chan_pp_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .lane_valid(lane_valid),
    .lane16_data(lane16_data)
);

`default_nettype wire

// ===== bench/lane_rx_model.sv
// Host-side lane receiver: captures each set of lane words.
// Assumes the lane words arrive on pclk together with lane_valid.
`timescale 1ns/10ps
`default_nettype none

module lane_rx_model (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Lane words from the block.
    input  wire logic        lane_valid,
    input  wire logic [13:0] lane13_data,
    input  wire logic [13:0] lane14_data,
    input  wire logic [13:0] lane15_data,
    input  wire logic [13:0] lane16_data,
    // Captured words and a count of sets.
    output logic      [13:0] got13,
    output logic      [13:0] got14,
    output logic      [13:0] got15,
    output logic      [13:0] got16,
    output logic      [15:0] n_sets
);
    // Take words only on lane_valid; held data between pulses is ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got13  <= 14'h0000;
            got14  <= 14'h0000;
            got15  <= 14'h0000;
            got16  <= 14'h0000;
            n_sets <= 16'h0000;
        end else if (lane_valid) begin
            got13  <= lane13_data;
            got14  <= lane14_data;
            got15  <= lane15_data;
            got16  <= lane16_data;
            n_sets <= n_sets + 16'h0001;
        end
    end
endmodule : lane_rx_model

`default_nettype wire

// ===== bench/test_chan_digital_post_process.sv
// Self-checking bench for the channel 13..16 post-processing block.
// Assumes the block, its package, the checker and the lane receiver.
`timescale 1ns/10ps
`default_nettype none

module test_chan_digital_post_process;
    logic        pclk, presetn, psel, penable, pwrite, sample_valid, pready, pslverr, err;
    logic        lane_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [13:0] s13, s14, s15, s16, l13, l14, l15, l16, g13, g14, g15, g16, w;
    logic [15:0] n_sets;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;

    chan_digital_post_process i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_ch13(s13), .sample_ch14(s14),
        .sample_ch15(s15), .sample_ch16(s16), .lane13_data(l13),
        .lane14_data(l14), .lane15_data(l15), .lane16_data(l16),
        .lane_valid(lane_valid));
    lane_rx_model i_rx (
        .pclk(pclk), .presetn(presetn), .lane_valid(lane_valid),
        .lane13_data(l13), .lane14_data(l14), .lane15_data(l15),
        .lane16_data(l16), .got13(g13), .got14(g14), .got15(g15),
        .got16(g16), .n_sets(n_sets));

    // ====================
    // Shared tasks
    // ====================
    // Compare, allowing a small rounding distance in tol.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
        n_checks++;
        if ($isunknown(got) || (int'(got) - int'(exp)) > tol || (int'(exp) - int'(got)) > tol) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo,
                       input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [9:0] idx, input logic [15:0] d);
        apb(1'b1, idx, 2'h0, d);
    endtask : wreg

    task automatic rchk(input logic [9:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 2'h0, 16'h0000);
        check(rd, {16'h0000, exp});
    endtask : rchk

    // One sample set; the inputs are scrambled once the sample is taken.
    task automatic send(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c,
                        input logic [13:0] d);
        logic [15:0] n0;
        int n;
        n0 = n_sets;
        @(posedge pclk);
        sample_valid <= 1'b1;
        {s13, s14, s15, s16} <= {a, b, c, d};
        @(posedge pclk);
        sample_valid <= 1'b0;
        {s13, s14, s15, s16} <= ~{a, b, c, d};
        n = 0;
        while (n_sets === n0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 10) check(32'h0000_0001, 32'h0000_0000);
    endtask : send

    // ====================
    // Scenarios
    // ====================
    task automatic t_regs();
        check({18'h0, l16}, 32'h0);
        rchk(chan_pp_pkg::IDX_GLOBAL_CTRL, 16'h0000);
        rchk(chan_pp_pkg::IDX_PAT_MODE, 16'h0000);
        rchk(chan_pp_pkg::IDX_GAIN_OFFSET, 16'h0000);
        rchk(chan_pp_pkg::IDX_OFFSET_COPY, 16'h0000);
        rchk(chan_pp_pkg::IDX_LANE_HPF, 16'h0000);
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h0046);
        rchk(chan_pp_pkg::IDX_LANE_HPF, 16'h0046);
        apb(1'b0, 10'h03A, 2'h0, 16'h0000);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, chan_pp_pkg::IDX_LANE_HPF, 2'h2, 16'h0001);
        check({31'h0, err}, 32'h1);
        rchk(chan_pp_pkg::IDX_LANE_HPF, 16'h0046);
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h0000);
    endtask : t_regs

    task automatic t_gain_offset();
        logic [31:0] e;
        wreg(chan_pp_pkg::IDX_GAIN_OFFSET, 16'h03FB);
        wreg(chan_pp_pkg::IDX_OFFSET_COPY, 16'h03FB);
        rchk(chan_pp_pkg::IDX_OFFSET_COPY, 16'h03FB);
        wreg(chan_pp_pkg::IDX_GLOBAL_CTRL, 16'h0100);
        send(14'd7, 14'd7, 14'd7, 14'd100);
        check({18'h0, g16}, 32'd95);
        check({18'h0, g13}, 32'd7);
        wreg(chan_pp_pkg::IDX_GLOBAL_CTRL, 16'h0000);
        send(14'd7, 14'd7, 14'd7, 14'd100);
        check({18'h0, g16}, 32'd100);
        wreg(chan_pp_pkg::IDX_GAIN_OFFSET, 16'hF800);
        wreg(chan_pp_pkg::IDX_OFFSET_COPY, 16'h0000);
        wreg(chan_pp_pkg::IDX_GLOBAL_CTRL, 16'h1000);
        send(14'd7, 14'd7, 14'd7, 14'd1000);
        e = (32'd1000 * {16'h0, chan_pp_pkg::GAIN_TABLE[31]}) >> chan_pp_pkg::GAIN_FRAC;
        check({18'h0, g16}, e);
        wreg(chan_pp_pkg::IDX_GLOBAL_CTRL, 16'h0000);
        send(14'd7, 14'd7, 14'd7, 14'd1000);
        check({18'h0, g16}, 32'd1000);
        wreg(chan_pp_pkg::IDX_GAIN_OFFSET, 16'h0000);
    endtask : t_gain_offset

    task automatic t_patterns();
        wreg(chan_pp_pkg::IDX_PAT_MODE, 16'h0100);
        for (int c = 1; c <= 4; c++) begin
            wreg(chan_pp_pkg::IDX_LANE_HPF, {4'h0, 3'(c), 3'(c), 6'h00});
            send(14'd11, 14'd22, 14'd33, 14'd44);
            // Ramp counts sets since reset; toggle opens with its first word.
            w = (c == 1) ? 14'h0000 : (c == 2) ? 14'h3FFF :
                (c == 4) ? 14'(n_sets - 16'h0001) :
                n_sets[0] ? chan_pp_pkg::TOGGLE_A : chan_pp_pkg::TOGGLE_B;
            check({18'h0, g13}, {18'h0, w});
            check({18'h0, g14}, {18'h0, w});
            check({18'h0, g15}, 32'd33);
        end
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h2000);
        send(14'd11, 14'd22, 14'd33, 14'd44);
        w = g15;
        check({18'h0, g13 ^ g16}, 32'd11 ^ 32'd44);
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'hF000);
        send(14'd11, 14'd22, 14'd33, 14'd44);
        check({31'h0, g15 !== 14'd33 && g15 !== w && g13 !== 14'd11 && g16 !== 14'd44}, 1);
        wreg(chan_pp_pkg::IDX_PAT_MODE, 16'h0000);
        send(14'd11, 14'd22, 14'd33, 14'd44);
        check({4'h0, g13, g15}, {4'h0, 14'd11, 14'd33});
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h0000);
    endtask : t_patterns

    task automatic t_highpass();
        send(14'd0, 14'd0, 14'd0, 14'd0);
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h0005);
        send(14'd1000, 14'd0, 14'd0, 14'd1000);
        check({18'h0, g16}, 32'd800, 3);
        check({18'h0, g13}, 32'd800, 3);
        send(14'd1000, 14'd0, 14'd0, 14'd1000);
        check({18'h0, g16}, 32'd640, 3);
        wreg(chan_pp_pkg::IDX_LANE_HPF, 16'h0000);
        send(14'd1000, 14'd0, 14'd0, 14'd1000);
        check({18'h0, g16}, 32'd1000);
    endtask : t_highpass

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ====================
    // Clock, timeout and main sequence
    // ====================
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Cuts a hang short well beyond the expected run length.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            $display("ERROR %0t timeout", $time);
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, sample_valid} = 5'h00;
        {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hF};
        {s13, s14, s15, s16} = 56'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gain_offset();
        t_patterns();
        t_highpass();
        complete_run();
    end
endmodule : test_chan_digital_post_process

`default_nettype wire
